/* File: bsx_exec.sv */
// instruction execution block with axi4-lite register access
//
// Function
// - Skip-if-set discards the next instruction as a nop when the bit is one.
// - Skip-if-clear discards the next instruction as a nop when the bit is zero.
// - Clear-file writes zero into file register 0..127 and sets zero.
// - Clear-work loads zero into the work register and sets zero.
// - Call pushes pc plus one on the stack and costs two cycles.
// - Jump leaves stack and flags alone and costs two cycles.
// - Clear-watchdog zeroes counter and prescaler, sets timeout and powerdown.
// - Complement inverts the file register into the destination, updates zero.
// - Destination bit zero targets the work register, one the file register.
// - Decrement stores file minus one at the destination, updates zero.
// - Increment stores file plus one at the destination, updates zero.
// - Decrement-skip stores the result, keeps flags, skips next on zero.
// - Increment-skip stores the result, keeps flags, skips next on zero.
module bsx_exec #(
   parameter int STACK_DEPTH = 8,
   parameter int WDT_W = 8,
   parameter int PRE_W = 7
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wdt_expired
);

   localparam int SP_W = $clog2(STACK_DEPTH);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FSM_IDLE,
      FSM_FETCH,
      FSM_RD_WAIT
   } bsx_fsm_t;
   typedef struct packed {
      bsx_fsm_t fsm;
      logic [31:0] instr;
      logic skip;
      logic [7:0] work;
      logic zero;
      logic timeout_flag;
      logic powerdown_flag;
      logic [bsx_pkg::PC_W-1:0] pc;
      logic [bsx_pkg::LATCH_W-1:0] upper_address_latch;
      logic [STACK_DEPTH-1:0][bsx_pkg::PC_W-1:0] stack;
      logic [SP_W-1:0] sp;
      logic [WDT_W-1:0] watchdog_counter;
      logic [PRE_W-1:0] prescaler;
      logic expired;
      logic [31:0] cycles;
      logic [bsx_pkg::FSEL_W-1:0] faddr;
      logic aw_h;
      logic w_h;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } bsx_state_t;

   bsx_state_t st_r;
   bsx_state_t st_nxt;
   logic ram_we;
   logic [bsx_pkg::FSEL_W-1:0] ram_addr;
   logic [7:0] ram_wdata;
   logic [7:0] ram_rdata;
   logic wr_go;
   logic ar_go;
   logic [31:0] ins;
   logic [3:0] op;
   logic dest;
   logic [bsx_pkg::BSEL_W-1:0] bsel;
   logic [bsx_pkg::FSEL_W-1:0] fsel;
   logic [bsx_pkg::LIT_W-1:0] lit;
   logic [7:0] res;
   logic [bsx_pkg::PC_W-1:0] stack_top;
   logic [31:0] status_word;
   logic [31:0] cyc_branch;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [bsx_pkg::PC_W-1:0] jump_target(
      input logic [bsx_pkg::LIT_W-1:0] k,
      input logic [bsx_pkg::LATCH_W-1:0] latch
   );
      return {latch[bsx_pkg::LATCH_HI:bsx_pkg::LATCH_LO], k};
   endfunction

   function automatic logic [7:0] alu(
      input logic [3:0] code,
      input logic [7:0] v
   );
      case (code)
         bsx_pkg::OP_COMPLEMENT_FILE_REG: return ~v;
         bsx_pkg::OP_DECREMENT_FILE_REG,
         bsx_pkg::OP_DECREMENT_SKIP_ZERO: return v - 8'h01;
         bsx_pkg::OP_INCREMENT_FILE_REG,
         bsx_pkg::OP_INCREMENT_SKIP_ZERO: return v + 8'h01;
         default: return 8'h00;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   // a fresh command decodes from the held write data, a fetch from instr
   assign ins = (st_r.fsm == FSM_FETCH) ? st_r.instr : st_r.wdata;
   assign op = ins[bsx_pkg::OP_LSB +: bsx_pkg::OP_W];
   assign dest = ins[bsx_pkg::DEST_BIT];
   assign bsel = ins[bsx_pkg::BSEL_LSB +: bsx_pkg::BSEL_W];
   assign fsel = ins[bsx_pkg::FSEL_LSB +: bsx_pkg::FSEL_W];
   assign lit = ins[bsx_pkg::LIT_LSB +: bsx_pkg::LIT_W];
   assign res = alu(op, ram_rdata);
   assign stack_top = st_r.stack[st_r.sp - 1'b1];
   assign cyc_branch = st_r.cycles + bsx_pkg::BRANCH_CYCLES;

   always_comb begin
      status_word = 32'h0;
      status_word[bsx_pkg::ST_BUSY] = st_r.fsm != FSM_IDLE;
      status_word[bsx_pkg::ST_SKIP] = st_r.skip;
      status_word[bsx_pkg::ST_ZERO] = st_r.zero;
      status_word[bsx_pkg::ST_TIMEOUT] = st_r.timeout_flag;
      status_word[bsx_pkg::ST_PWRDN] = st_r.powerdown_flag;
   end

   // ----------------------------------------------------------------
   // bus handshakes
   // ----------------------------------------------------------------
   assign s_axi_awready = !st_r.aw_h && !st_r.bvalid;
   assign s_axi_wready = !st_r.w_h && !st_r.bvalid;
   assign wr_go = st_r.aw_h && st_r.w_h && (st_r.fsm == FSM_IDLE);
   assign s_axi_arready = (st_r.fsm == FSM_IDLE) && !st_r.rvalid && !wr_go;
   assign ar_go = s_axi_arvalid && s_axi_arready;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rresp = st_r.rresp;
   assign s_axi_rdata = st_r.rdata;
   assign wdt_expired = st_r.expired;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.expired = 1'b0;
      ram_we = 1'b0;
      ram_addr = st_r.faddr;
      ram_wdata = 8'h00;

      // watchdog advances on every prescaler wrap
      st_nxt.prescaler = st_r.prescaler + 1'b1;
      if (&st_r.prescaler) begin
         st_nxt.watchdog_counter = st_r.watchdog_counter + 1'b1;
         if (&st_r.watchdog_counter) begin
            st_nxt.timeout_flag = 1'b0;
            st_nxt.expired = 1'b1;
         end
      end

      if (st_r.bvalid && s_axi_bready) st_nxt.bvalid = 1'b0;
      if (st_r.rvalid && s_axi_rready) st_nxt.rvalid = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         st_nxt.aw_h = 1'b1;
         st_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_nxt.w_h = 1'b1;
         st_nxt.wdata = s_axi_wdata;
         st_nxt.wstrb0 = s_axi_wstrb[0];
      end

      // register writes; a word with lane 0 off has no effect
      if (wr_go) begin
         st_nxt.aw_h = 1'b0;
         st_nxt.w_h = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = bsx_pkg::RESP_OKAY;
         case (st_r.awaddr)
            bsx_pkg::REG_CMD: begin
               if (st_r.wstrb0) begin
                  st_nxt.instr = st_r.wdata;
                  st_nxt.pc = st_r.pc + 1'b1;
                  st_nxt.cycles = st_r.cycles + bsx_pkg::PLAIN_CYCLES;
                  if (st_r.skip) begin
                     // discarded instruction runs as a nop
                     st_nxt.skip = 1'b0;
                  end else begin
                     case (op)
                        bsx_pkg::OP_CLEAR_FILE_REG: begin
                           ram_we = 1'b1;
                           ram_addr = fsel;
                           st_nxt.zero = 1'b1;
                        end
                        bsx_pkg::OP_CLEAR_WORK_REG: begin
                           st_nxt.work = 8'h00;
                           st_nxt.zero = 1'b1;
                        end
                        bsx_pkg::OP_CALL: begin
                           st_nxt.stack[st_r.sp] = st_r.pc + 1'b1;
                           st_nxt.sp = st_r.sp + 1'b1;
                           st_nxt.pc = jump_target(lit,
                              st_r.upper_address_latch);
                           st_nxt.cycles = cyc_branch;
                        end
                        bsx_pkg::OP_JUMP_ABSOLUTE: begin
                           st_nxt.pc = jump_target(lit,
                              st_r.upper_address_latch);
                           st_nxt.cycles = cyc_branch;
                        end
                        bsx_pkg::OP_CLEAR_WATCHDOG: begin
                           st_nxt.watchdog_counter = '0;
                           st_nxt.prescaler = '0;
                           st_nxt.timeout_flag = 1'b1;
                           st_nxt.powerdown_flag = 1'b1;
                           st_nxt.expired = 1'b0;
                        end
                        bsx_pkg::OP_BIT_TEST_SKIP_IF_SET,
                        bsx_pkg::OP_BIT_TEST_SKIP_IF_CLEAR,
                        bsx_pkg::OP_COMPLEMENT_FILE_REG,
                        bsx_pkg::OP_DECREMENT_FILE_REG,
                        bsx_pkg::OP_INCREMENT_FILE_REG,
                        bsx_pkg::OP_DECREMENT_SKIP_ZERO,
                        bsx_pkg::OP_INCREMENT_SKIP_ZERO: begin
                           ram_addr = fsel;
                           st_nxt.fsm = FSM_FETCH;
                        end
                        default: ;
                     endcase
                  end
               end
            end
            bsx_pkg::REG_WREG:
               if (st_r.wstrb0) st_nxt.work = st_r.wdata[7:0];
            bsx_pkg::REG_PC:
               if (st_r.wstrb0) st_nxt.pc = st_r.wdata[bsx_pkg::PC_W-1:0];
            bsx_pkg::REG_LATCH:
               if (st_r.wstrb0) st_nxt.upper_address_latch =
                  st_r.wdata[bsx_pkg::LATCH_W-1:0];
            bsx_pkg::REG_FADDR:
               if (st_r.wstrb0) st_nxt.faddr = st_r.wdata[bsx_pkg::FSEL_W-1:0];
            bsx_pkg::REG_FDATA: begin
               ram_we = st_r.wstrb0;
               ram_wdata = st_r.wdata[7:0];
            end
            bsx_pkg::REG_STATUS, bsx_pkg::REG_STACK_TOP,
            bsx_pkg::REG_WDT, bsx_pkg::REG_CYCLES: ;
            default: st_nxt.bresp = bsx_pkg::RESP_SLVERR;
         endcase
      end

      // register reads
      if (ar_go) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = bsx_pkg::RESP_OKAY;
         st_nxt.rdata = 32'h0;
         case (s_axi_araddr)
            bsx_pkg::REG_CMD: st_nxt.rdata = st_r.instr;
            bsx_pkg::REG_STATUS: st_nxt.rdata = status_word;
            bsx_pkg::REG_WREG: st_nxt.rdata = 32'(st_r.work);
            bsx_pkg::REG_PC: st_nxt.rdata = 32'(st_r.pc);
            bsx_pkg::REG_LATCH: st_nxt.rdata = 32'(st_r.upper_address_latch);
            bsx_pkg::REG_STACK_TOP: st_nxt.rdata = 32'(stack_top);
            bsx_pkg::REG_WDT: st_nxt.rdata = 32'(st_r.watchdog_counter);
            bsx_pkg::REG_FADDR: st_nxt.rdata = 32'(st_r.faddr);
            bsx_pkg::REG_CYCLES: st_nxt.rdata = st_r.cycles;
            bsx_pkg::REG_FDATA: begin
               // memory answers one cycle later
               st_nxt.rvalid = 1'b0;
               st_nxt.fsm = FSM_RD_WAIT;
            end
            default: st_nxt.rresp = bsx_pkg::RESP_SLVERR;
         endcase
      end

      case (st_r.fsm)
         FSM_IDLE: ;
         FSM_FETCH: begin
            st_nxt.fsm = FSM_IDLE;
            case (op)
               bsx_pkg::OP_BIT_TEST_SKIP_IF_SET:
                  st_nxt.skip = ram_rdata[bsx_pkg::BSEL_W'(bsel)];
               bsx_pkg::OP_BIT_TEST_SKIP_IF_CLEAR:
                  st_nxt.skip = !ram_rdata[bsel];
               bsx_pkg::OP_DECREMENT_SKIP_ZERO,
               bsx_pkg::OP_INCREMENT_SKIP_ZERO:
                  st_nxt.skip = res == 8'h00;
               default:
                  st_nxt.zero = res == 8'h00;
            endcase
            if (op != bsx_pkg::OP_BIT_TEST_SKIP_IF_SET &&
                op != bsx_pkg::OP_BIT_TEST_SKIP_IF_CLEAR) begin
               if (dest == bsx_pkg::DEST_FILE) begin
                  ram_we = 1'b1;
                  ram_addr = fsel;
                  ram_wdata = res;
               end else begin
                  st_nxt.work = res;
               end
            end
         end
         FSM_RD_WAIT: begin
            st_nxt.fsm = FSM_IDLE;
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = 32'(ram_rdata);
         end
         default: st_nxt.fsm = FSM_IDLE;
      endcase

      if (!aresetn) begin
         st_nxt = '0;
         st_nxt.zero = bsx_pkg::RST_ZERO;
         st_nxt.timeout_flag = bsx_pkg::RST_TIMEOUT;
         st_nxt.powerdown_flag = bsx_pkg::RST_PWRDN;
         ram_we = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      st_r <= st_nxt;
   end

   // ----------------------------------------------------------------
   // file register memory
   // ----------------------------------------------------------------
   bsx_file_ram #(
      .AW(bsx_pkg::FSEL_W),
      .DW(8)
   ) u_ram (
      .clk(aclk),
      .we(ram_we),
      .addr(ram_addr),
      .wdata(ram_wdata),
      .rdata(ram_rdata)
   );

endmodule

/* File: bsx_pkg.sv */
// shared constants for the instruction execution block
package bsx_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_WREG = 8'h08;
   localparam logic [7:0] REG_PC = 8'h0c;
   localparam logic [7:0] REG_LATCH = 8'h10;
   localparam logic [7:0] REG_STACK_TOP = 8'h14;
   localparam logic [7:0] REG_WDT = 8'h18;
   localparam logic [7:0] REG_FADDR = 8'h1c;
   localparam logic [7:0] REG_FDATA = 8'h20;
   localparam logic [7:0] REG_CYCLES = 8'h24;

   // ----------------------------------------------------------------
   // status register bit positions
   // ----------------------------------------------------------------
   localparam int ST_BUSY = 0;
   localparam int ST_SKIP = 1;
   localparam int ST_ZERO = 2;
   localparam int ST_TIMEOUT = 3;
   localparam int ST_PWRDN = 4;

   // ----------------------------------------------------------------
   // instruction word layout
   // ----------------------------------------------------------------
   localparam int OP_LSB = 0;
   localparam int OP_W = 4;
   localparam int DEST_BIT = 4;
   localparam int BSEL_LSB = 5;
   localparam int BSEL_W = 3;
   localparam int FSEL_LSB = 8;
   localparam int FSEL_W = 7;
   localparam int LIT_LSB = 16;
   localparam int LIT_W = 11;
   localparam int PC_W = 13;
   localparam int LATCH_W = 5;
   localparam int LATCH_HI = 4;
   localparam int LATCH_LO = 3;
   localparam logic DEST_WORK = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // ----------------------------------------------------------------
   // operation codes
   // ----------------------------------------------------------------
   localparam logic [3:0] OP_NOP = 4'h0;
   localparam logic [3:0] OP_BIT_TEST_SKIP_IF_SET = 4'h1;
   localparam logic [3:0] OP_BIT_TEST_SKIP_IF_CLEAR = 4'h2;
   localparam logic [3:0] OP_CLEAR_FILE_REG = 4'h3;
   localparam logic [3:0] OP_CLEAR_WORK_REG = 4'h4;
   localparam logic [3:0] OP_CALL = 4'h5;
   localparam logic [3:0] OP_JUMP_ABSOLUTE = 4'h6;
   localparam logic [3:0] OP_CLEAR_WATCHDOG = 4'h7;
   localparam logic [3:0] OP_COMPLEMENT_FILE_REG = 4'h8;
   localparam logic [3:0] OP_DECREMENT_FILE_REG = 4'h9;
   localparam logic [3:0] OP_INCREMENT_FILE_REG = 4'ha;
   localparam logic [3:0] OP_DECREMENT_SKIP_ZERO = 4'hb;
   localparam logic [3:0] OP_INCREMENT_SKIP_ZERO = 4'hc;

   // ----------------------------------------------------------------
   // reset values, cycle costs, bus answers
   // ----------------------------------------------------------------
   localparam logic RST_ZERO = 1'b0;
   localparam logic RST_TIMEOUT = 1'b1;
   localparam logic RST_PWRDN = 1'b1;
   localparam logic [31:0] PLAIN_CYCLES = 32'h1;
   localparam logic [31:0] BRANCH_CYCLES = 32'h2;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

/* File: bsx_file_ram.sv */
// file register memory with registered read data
module bsx_file_ram #(
   parameter int AW = 7,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [DW-1:0] rdata_r;

   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata_r <= mem[addr];
   end

   assign rdata = rdata_r;

endmodule

/* File: bsx_exec_props.sv */
// port assertions for the execution block
module bsx_exec_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic wdt_expired
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------
   // clocking
   // ------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ------------
   // bus and watchdog relations
   // ------------
   property p_rst;
      $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !wdt_expired;
   endproperty
   a_rst: assert property (p_rst)
      else $error("outputs busy after reset");
   property p_wr_ans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##[1:4] s_axi_bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans)
      else $error("write response late");
   property p_rd_ans;
      s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans)
      else $error("read data late");
   property p_aw_ref;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_aw_ref: assert property (p_aw_ref)
      else $error("write taken while response pending");
   property p_ar_ref;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_ref: assert property (p_ar_ref)
      else $error("read taken while data pending");
   property p_b_done;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_done: assert property (p_b_done)
      else $error("write response not retired");
   property p_r_done;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_done: assert property (p_r_done)
      else $error("read data not retired");
   property p_wdt;
      wdt_expired |=> !wdt_expired;
   endproperty
   a_wdt: assert property (p_wdt)
      else $error("expiry pulse too long");
endmodule

/* File: test_bsx_exec.sv */
// self-checking bench for the execution block
module test_bsx_exec;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------
   // signals and model state
   // ------------
   localparam logic [3:0] OPS [7] = '{bsx_pkg::OP_CLEAR_FILE_REG,
      bsx_pkg::OP_CLEAR_WORK_REG, bsx_pkg::OP_COMPLEMENT_FILE_REG,
      bsx_pkg::OP_DECREMENT_FILE_REG, bsx_pkg::OP_INCREMENT_FILE_REG,
      bsx_pkg::OP_DECREMENT_SKIP_ZERO, bsx_pkg::OP_INCREMENT_SKIP_ZERO};
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, wdt_expired;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   int num_errors = 0, tests_run = 0;
   int m_w, m_pc, m_lat, m_z, m_to = 1, m_pd = 1, m_skip, m_cyc, m_top;
   bit m_called;
   int mem [128];

   always #4 aclk = ~aclk;
   always @(posedge aclk) if (wdt_expired === 1'h1) m_to <= 0;

   bsx_exec #(.WDT_W(4), .PRE_W(7)) uut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .wdt_expired
   );

   // ------------
   // bus and check tasks
   // ------------
   task automatic conclude;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] a, e, v);
      tests_run++;
      if (v !== e) begin
         num_errors++;
         $display("Error reg %h expected %h seen %h", a, e, v);
      end
   endtask

   task automatic tmo(input int n);
      if (n >= 200) begin
         num_errors++;
         $display("Error bus wait timed out");
         conclude();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1 && n < 200);
      s_axi_bready <= 1'h0;
      tmo(n);
      chk({24'h0, a}, {30'h0, er}, {30'h0, s_axi_bresp});
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e, m,
         input logic [1:0] er = bsx_pkg::RESP_OKAY);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1 && n < 200);
      s_axi_rready <= 1'h0;
      tmo(n);
      chk({24'h0, a}, e & m, s_axi_rdata & m);
      chk({24'h0, a}, {30'h0, er}, {30'h0, s_axi_rresp});
   endtask

   function automatic logic [31:0] stat();
      return m_pd * 16 + m_to * 8 + m_z * 4 + m_skip * 2;
   endfunction

   task automatic setf(input int f, v);
      mem[f] = v;
      wr(bsx_pkg::REG_FADDR, f, 4'hf, bsx_pkg::RESP_OKAY);
      wr(bsx_pkg::REG_FDATA, v, 4'hf, bsx_pkg::RESP_OKAY);
   endtask

   task automatic regs(input int f);
      wr(bsx_pkg::REG_FADDR, f, 4'hf, bsx_pkg::RESP_OKAY);
      rc(bsx_pkg::REG_WREG, m_w, 32'hff);
      rc(bsx_pkg::REG_PC, m_pc, 32'h1fff);
      rc(bsx_pkg::REG_STATUS, stat(), 32'h1e);
      rc(bsx_pkg::REG_CYCLES, m_cyc, 32'hffffffff);
      rc(bsx_pkg::REG_FDATA, mem[f], 32'hff);
      if (m_called) rc(bsx_pkg::REG_STACK_TOP, m_top, 32'h1fff);
   endtask

   // executes one instruction in the model and the design, then compares
   task automatic run(input logic [3:0] op, input int d, b, f, k);
      int r;
      r = mem[f];
      wr(bsx_pkg::REG_CMD, {5'h0, k[10:0], 1'h0, f[6:0], b[2:0], d[0], op},
         4'hf, bsx_pkg::RESP_OKAY);
      if (m_skip) begin
         m_skip = 0;
         op = bsx_pkg::OP_NOP;
      end
      m_pc = (m_pc + 1) % 8192;
      m_cyc++;
      case (op)
         bsx_pkg::OP_BIT_TEST_SKIP_IF_SET: m_skip = r >> b & 1;
         bsx_pkg::OP_BIT_TEST_SKIP_IF_CLEAR:
            m_skip = ~r >> b & 1;
         bsx_pkg::OP_CLEAR_FILE_REG: begin
            mem[f] = 0;
            m_z = 1;
         end
         bsx_pkg::OP_CLEAR_WORK_REG: begin
            m_w = 0;
            m_z = 1;
         end
         bsx_pkg::OP_CALL, bsx_pkg::OP_JUMP_ABSOLUTE: begin
            if (op == bsx_pkg::OP_CALL) begin
               m_top = m_pc;
               m_called = 1;
            end
            m_pc = (m_lat >> 3) * 2048 + k;
            m_cyc++;
         end
         bsx_pkg::OP_CLEAR_WATCHDOG: begin
            m_to = 1;
            m_pd = 1;
         end
         bsx_pkg::OP_COMPLEMENT_FILE_REG: r = ~r;
         bsx_pkg::OP_DECREMENT_FILE_REG,
         bsx_pkg::OP_DECREMENT_SKIP_ZERO: r--;
         bsx_pkg::OP_INCREMENT_FILE_REG,
         bsx_pkg::OP_INCREMENT_SKIP_ZERO: r++;
         default: ;
      endcase
      if (op >= bsx_pkg::OP_COMPLEMENT_FILE_REG) begin
         r &= 255;
         if (d) mem[f] = r;
         else m_w = r;
         if (op >= bsx_pkg::OP_DECREMENT_SKIP_ZERO)
            m_skip = r == 0;
         else m_z = r == 0;
      end
      regs(f);
   endtask

   // ------------
   // main sequence
   // ------------
   initial begin
      int f;
      int v;
      void'($urandom(32'he6d8));
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      rc(bsx_pkg::REG_STATUS, stat(), 32'h1f);
      rc(bsx_pkg::REG_PC, 32'h0, 32'h1fff);
      rc(8'h40, 32'h0, 32'hffffffff, bsx_pkg::RESP_SLVERR);
      wr(8'h40, 32'h5a, 4'hf, bsx_pkg::RESP_SLVERR);
      wr(bsx_pkg::REG_WREG, 32'h77, 4'h0, bsx_pkg::RESP_OKAY);
      rc(bsx_pkg::REG_WREG, 32'h0, 32'hff);
      // watchdog wrap clears the timeout flag, then the clear restores it
      setf(0, $urandom % 256);
      for (int n = 0; n < 3000 && wdt_expired !== 1'h1; n++) @(posedge aclk);
      if (wdt_expired !== 1'h1) tmo(200);
      repeat (200) @(posedge aclk);
      regs(0);
      run(bsx_pkg::OP_CLEAR_WATCHDOG, 0, 0, 0, 0);
      rc(bsx_pkg::REG_WDT, 32'h0, 32'hff);
      // branches with every latch upper pair
      m_pc = 32'h0abc;
      wr(bsx_pkg::REG_PC, m_pc, 4'hf, bsx_pkg::RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         m_lat = i * 8 + 7;
         wr(bsx_pkg::REG_LATCH, m_lat, 4'hf, bsx_pkg::RESP_OKAY);
         run(i[0] ? bsx_pkg::OP_CALL : bsx_pkg::OP_JUMP_ABSOLUTE, 0, 0, 0,
            i == 3 ? 2047 : $urandom % 2048);
      end
      // bit tests, each followed by an instruction that may be discarded
      for (int b = 0; b < 8; b++) begin
         f = 127 - b * 9;
         setf(f, $urandom % 256);
         run(bsx_pkg::OP_BIT_TEST_SKIP_IF_SET, 0, b, f, 0);
         run(bsx_pkg::OP_INCREMENT_FILE_REG, 1, 0, f, 0);
         run(bsx_pkg::OP_BIT_TEST_SKIP_IF_CLEAR, 0, b, f, 0);
         run(bsx_pkg::OP_INCREMENT_FILE_REG, 0, 0, f, 0);
      end
      // file operations on both destinations at the wrap values
      for (int i = 0; i < 42; i++) begin
         f = $urandom % 128;
         v = i % 3 == 0 ? 0 : i % 3 == 1 ? 1 : 255;
         setf(f, v);
         run(OPS[i / 6], i / 3 % 2, 0, f, 0);
      end
      conclude();
   end
endmodule

bind bsx_exec bsx_exec_props u_props (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .wdt_expired
);
